// ===== verilog/jsd_pkg.sv
// shared constants for the jack sense filter block
package jsd_pkg;
    localparam int CLK_HZ        = 25_000_000;
    localparam int UNIT_US       = 1000;
    localparam int UNIT_CYCLES   = (CLK_HZ / 1_000_000) * UNIT_US;
    localparam int CODE_W        = 3;
    localparam int CNT_W         = 20;
    localparam int ADR_W         = 8;

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_TIME   = 8'h04;
    localparam logic [7:0] ADDR_MASK   = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;

    localparam int C_PDN       = 0;
    localparam int C_LATCH     = 1;
    localparam int C_RING_ACT  = 2;
    localparam int C_TIP_CTL   = 3;
    localparam int C_TIP_FLIP  = 5;
    localparam int C_RING_FLIP = 6;
    localparam int C_GATE      = 7;
    localparam int C_MON_ACT   = 8;
    localparam int C_TIP_FE    = 9;
    localparam int CTRL_W      = 10;
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h001;

    localparam int T_TIP_FALL  = 0;
    localparam int T_TIP_RISE  = 4;
    localparam int T_RING_FALL = 8;
    localparam int T_RING_RISE = 12;
    localparam int TIME_W      = 16;
    localparam logic [TIME_W-1:0] TIME_RST = 16'h1111;

    localparam int M_TIP       = 0;
    localparam int M_RING      = 1;
    localparam int M_BROWN     = 2;
    localparam int MASK_W      = 3;
    localparam logic [MASK_W-1:0] MASK_RST = 3'h7;

    localparam int S_TIP_INS   = 0;
    localparam int S_TIP_UNP   = 1;
    localparam int S_RING_INS  = 2;
    localparam int S_RING_UNP  = 3;
    localparam int S_TIP_PRES  = 4;
    localparam int S_RING_PRES = 5;
    localparam int S_BROWN     = 6;
    localparam int S_BUS_SEL   = 7;
    localparam int S_TIP_RAW   = 8;
    localparam int S_RING_RAW  = 9;
    localparam int STAT_W      = 10;
endpackage

// ===== verilog/jsd_sync.sv
// three-stage pin synchroniser, output moves once stages two and three agree
module jsd_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_resetn,
    input  wire logic [WIDTH-1:0] i_pin,
    output logic      [WIDTH-1:0] o_level
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] next_level;

    always_comb begin
        next_level = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & o_level);
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s1      <= '0;
            s2      <= '0;
            s3      <= '0;
            o_level <= '0;
        end else begin
            s1      <= i_pin;
            s2      <= s1;
            s3      <= s2;
            o_level <= next_level;
        end
    end
endmodule

// ===== verilog/jsd_filter.sv
// plug/unplug debounce for one sense contact
module jsd_filter
    import jsd_pkg::*;
#(
    parameter int UNIT = jsd_pkg::UNIT_CYCLES
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_enable,
    input  wire logic              i_level,
    input  wire logic [CODE_W-1:0] i_rise_code,
    input  wire logic [CODE_W-1:0] i_fall_code,
    output logic                   o_plugged,
    output logic                   o_unplug
);
    logic [CNT_W-1:0] cnt;
    logic             prev;
    logic [CNT_W-1:0] next_cnt;
    logic             next_plugged;
    logic             next_unplug;

    function automatic logic [CNT_W-1:0] limit(input logic [CODE_W-1:0] code);
        limit = CNT_W'(code * UNIT);
    endfunction

    always_comb begin
        next_cnt     = CNT_W'(0);
        next_plugged = 1'b0;
        next_unplug  = 1'b0;
        if (i_enable) begin
            if (i_level) begin
                next_unplug  = 1'b1;
                next_plugged = o_plugged;
                if (prev && !o_plugged) begin
                    if (cnt >= limit(i_rise_code)) begin
                        next_plugged = 1'b1;
                    end else begin
                        next_cnt = cnt + CNT_W'(1);
                    end
                end
            end else begin
                next_unplug = o_unplug;
                if (prev || !o_unplug) begin
                    next_cnt = CNT_W'(0);
                end else if (cnt >= limit(i_fall_code)) begin
                    next_unplug = 1'b0;
                end else begin
                    next_cnt = cnt + CNT_W'(1);
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt       <= '0;
            prev      <= 1'b0;
            o_plugged <= 1'b0;
            o_unplug  <= 1'b0;
        end else begin
            cnt       <= next_cnt;
            prev      <= i_level;
            o_plugged <= next_plugged;
            o_unplug  <= next_unplug;
        end
    end

    a_plug_waits: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        $rose(o_plugged) |-> $past(cnt) >= limit($past(i_rise_code)))
        else $error("plugged rose before insertion time");
    a_no_reserved: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        o_plugged |-> o_unplug)
        else $error("reserved status pair seen");
endmodule

// ===== verilog/jsd_top.sv
// jack sense filter, gating, supply monitor status and wishbone registers
// Notes on behaviour
// - tip unplug bit drops only after tip removal time of steady removal.
// - tip plugged bit rises only after tip insertion time of steady presence.
// - ring unplug bit drops only after ring removal time.
// - ring plugged bit rises only after ring insertion time.
// - tip removal time comes from its own tip setting field.
// - tip and ring each have separate rise and fall time fields.
// - ring filter runs only while its active-low powerdown bit is one.
// - tip filter enabled by tip control codes 01 or 11.
// - status reads give the live condition, no captured event latch.
// - plug/unplug pair: 00 removed, 01 transitional, 11 inserted, 10 reserved.
// - with gating, ring present needs ring and tip both detected.
// - with gating, tip present is suppressed while ring is detected.
// - polarity flip applies before gating.
// - supply monitor runs only while its active-low powerdown bit is one.
// - supply under trip sets brown-out status; interrupt only while unmasked.
// - brown-out persists until supply rises above recovery level.
// - control bus select captured at reset release, never changes after.
//
// The implementer's own choices: the register addresses and register access over Wishbone.
module jsd_top
    import jsd_pkg::*;
#(
    parameter int UNIT = jsd_pkg::UNIT_CYCLES
) (
    input  wire logic                     i_core_clk,
    input  wire logic                     i_resetn,
    input  wire logic                     i_wb_cyc,
    input  wire logic                     i_wb_stb,
    input  wire logic                     i_wb_we,
    input  wire logic [jsd_pkg::ADR_W-1:0] i_wb_adr,
    input  wire logic [3:0]               i_wb_sel,
    input  wire logic [31:0]              i_wb_dat,
    output logic      [31:0]              o_wb_dat,
    output logic                          o_wb_ack,
    input  wire logic                     i_tip_sense,
    input  wire logic                     i_ring_sense,
    input  wire logic                     i_supply_below_trip,
    input  wire logic                     i_supply_above_recovery,
    input  wire logic                     i_control_bus_select,
    output logic                          o_control_bus_select,
    output logic                          o_tip_frontend_en,
    output logic                          o_supply_monitor_en,
    output logic                          o_irq
);
    import jsd_pkg::*;

    logic [CTRL_W-1:0] ctrl;
    logic [TIME_W-1:0] times;
    logic [MASK_W-1:0] mask;
    logic [CTRL_W-1:0] next_ctrl;
    logic [TIME_W-1:0] next_times;
    logic [MASK_W-1:0] next_mask;
    logic              next_ack;
    logic [31:0]       next_dat;
    logic              next_fe;
    logic              next_mon;

    logic              captured;
    logic              next_captured;
    logic              next_bus_sel;

    logic              brown;
    logic              next_brown;
    logic              tip_pres;
    logic              ring_pres;
    logic              next_tip_pres;
    logic              next_ring_pres;
    logic              next_irq;

    logic [3:0]        pins;
    logic              tip_raw;
    logic              ring_raw;
    logic              below_trip;
    logic              above_rec;
    logic              tip_det;
    logic              ring_det;
    logic              tip_en;
    logic              ring_en;
    logic              tip_ins;
    logic              tip_unp;
    logic              ring_ins;
    logic              ring_unp;
    logic              req;
    logic [STAT_W-1:0] status;

    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            lane_mask[b*8 +: 8] = {8{sel[b]}};
        end
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
        merge = (old & ~lane_mask(sel)) | (dat & lane_mask(sel));
    endfunction

    // pin synchronisers
    jsd_sync #(
        .WIDTH (4)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_pin      ({i_supply_above_recovery, i_supply_below_trip,
                      i_ring_sense, i_tip_sense}),
        .o_level    (pins)
    );

    assign tip_raw    = pins[0];
    assign ring_raw   = pins[1];
    assign below_trip = pins[2];
    assign above_rec  = pins[3];

    // detected states carry polarity before gating
    assign tip_det  = tip_raw ^ ctrl[C_TIP_FLIP];
    assign ring_det = ring_raw ^ ctrl[C_RING_FLIP];

    assign tip_en  = !ctrl[C_PDN] && o_tip_frontend_en && ctrl[C_TIP_CTL];
    assign ring_en = !ctrl[C_PDN] && ctrl[C_RING_ACT];

    jsd_filter #(
        .UNIT (UNIT)
    ) u_tip (
        .i_core_clk  (i_core_clk),
        .i_resetn    (i_resetn),
        .i_enable    (tip_en),
        .i_level     (tip_det),
        .i_rise_code (times[T_TIP_RISE +: CODE_W]),
        .i_fall_code (times[T_TIP_FALL +: CODE_W]),
        .o_plugged   (tip_ins),
        .o_unplug    (tip_unp)
    );

    jsd_filter #(
        .UNIT (UNIT)
    ) u_ring (
        .i_core_clk  (i_core_clk),
        .i_resetn    (i_resetn),
        .i_enable    (ring_en),
        .i_level     (ring_det),
        .i_rise_code (times[T_RING_RISE +: CODE_W]),
        .i_fall_code (times[T_RING_FALL +: CODE_W]),
        .o_plugged   (ring_ins),
        .o_unplug    (ring_unp)
    );

    // presence gating
    always_comb begin
        if (ctrl[C_GATE]) begin
            next_tip_pres  = tip_ins && !ring_ins;
            next_ring_pres = ring_ins && tip_ins;
        end else begin
            next_tip_pres  = tip_ins;
            next_ring_pres = ring_ins;
        end
    end

    // brown-out with hysteresis
    always_comb begin
        next_brown = brown;
        if (!o_supply_monitor_en) begin
            next_brown = 1'b0;
        end else if (below_trip) begin
            next_brown = 1'b1;
        end else if (above_rec) begin
            next_brown = 1'b0;
        end
    end

    // live status word, no capture
    always_comb begin
        status              = '0;
        status[S_TIP_INS]   = tip_ins;
        status[S_TIP_UNP]   = tip_unp;
        status[S_RING_INS]  = ring_ins;
        status[S_RING_UNP]  = ring_unp;
        status[S_TIP_PRES]  = tip_pres;
        status[S_RING_PRES] = ring_pres;
        status[S_BROWN]     = brown;
        status[S_BUS_SEL]   = o_control_bus_select;
        status[S_TIP_RAW]   = tip_raw;
        status[S_RING_RAW]  = ring_raw;
    end

    // live interrupt level
    always_comb begin
        next_irq = (tip_pres && !mask[M_TIP]) ||
                   (ring_pres && !mask[M_RING]) ||
                   (brown && !mask[M_BROWN]);
    end

    // bus slave and register file
    assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;

    always_comb begin
        next_ctrl          = ctrl;
        next_ctrl[C_LATCH] = 1'b0;
        next_times         = times;
        next_mask          = mask;
        next_ack           = req;
        next_dat           = '0;
        next_fe            = o_tip_frontend_en;
        next_mon           = o_supply_monitor_en;
        if (ctrl[C_LATCH]) begin
            next_fe  = ctrl[C_TIP_FE];
            next_mon = ctrl[C_MON_ACT];
        end
        if (req && i_wb_we) begin
            case (i_wb_adr)
                ADDR_CTRL: begin
                    next_ctrl = CTRL_W'(merge(32'(ctrl), i_wb_dat, i_wb_sel));
                end
                ADDR_TIME: begin
                    next_times = TIME_W'(merge(32'(times), i_wb_dat, i_wb_sel));
                end
                ADDR_MASK: begin
                    next_mask = MASK_W'(merge(32'(mask), i_wb_dat, i_wb_sel));
                end
                default: begin
                    next_ctrl[C_LATCH] = 1'b0;
                end
            endcase
        end else if (req) begin
            case (i_wb_adr)
                ADDR_CTRL: begin
                    next_dat = 32'(ctrl);
                end
                ADDR_TIME: begin
                    next_dat = 32'(times);
                end
                ADDR_MASK: begin
                    next_dat = 32'(mask);
                end
                ADDR_STATUS: begin
                    next_dat = 32'(status);
                end
                default: begin
                    next_dat = '0;
                end
            endcase
        end
    end

    // strap capture after reset release
    always_comb begin
        next_captured = 1'b1;
        next_bus_sel  = o_control_bus_select;
        if (!captured) begin
            next_bus_sel = i_control_bus_select;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl                 <= CTRL_RST;
            times                <= TIME_RST;
            mask                 <= MASK_RST;
            o_wb_ack             <= 1'b0;
            o_wb_dat             <= '0;
            o_tip_frontend_en    <= 1'b0;
            o_supply_monitor_en  <= 1'b0;
            captured             <= 1'b0;
            o_control_bus_select <= 1'b0;
            brown                <= 1'b0;
            tip_pres             <= 1'b0;
            ring_pres            <= 1'b0;
            o_irq                <= 1'b0;
        end else begin
            ctrl                 <= next_ctrl;
            times                <= next_times;
            mask                 <= next_mask;
            o_wb_ack             <= next_ack;
            o_wb_dat             <= next_dat;
            o_tip_frontend_en    <= next_fe;
            o_supply_monitor_en  <= next_mon;
            captured             <= next_captured;
            o_control_bus_select <= next_bus_sel;
            brown                <= next_brown;
            tip_pres             <= next_tip_pres;
            ring_pres            <= next_ring_pres;
            o_irq                <= next_irq;
        end
    end

    sequence s_req;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence

    sequence s_ack_once;
        o_wb_ack ##1 !o_wb_ack;
    endsequence

    // bus, latch, gating, supply and strap checks
    a_bus_ack_once: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        s_req |=> s_ack_once)
        else $error("ack not a single cycle after request");
    a_dat_idle_zero: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !o_wb_ack |-> o_wb_dat == '0)
        else $error("read data shown without ack");
    a_latch_applies: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        ctrl[C_LATCH] |=> o_tip_frontend_en == $past(ctrl[C_TIP_FE]) && o_supply_monitor_en == $past(ctrl[C_MON_ACT]))
        else $error("pending controls not applied after latch");
    a_gate_tip_off: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        ctrl[C_GATE] && ring_ins |=> !tip_pres)
        else $error("tip present while ring detected under gating");
    a_gate_ring_need: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        ctrl[C_GATE] && !tip_ins |=> !ring_pres)
        else $error("ring present without tip under gating");
    a_plain_presence: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !ctrl[C_GATE] |=> tip_pres == $past(tip_ins) && ring_pres == $past(ring_ins))
        else $error("presence differs from detected state");
    a_irq_live: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        brown && !mask[M_BROWN] |=> o_irq)
        else $error("unmasked brown-out gave no interrupt");
    a_brown_masked: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        mask[M_BROWN] && !tip_pres && !ring_pres |=> !o_irq)
        else $error("masked brown-out gave an interrupt");
    a_irq_quiet: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !tip_pres && !ring_pres && !brown |=> !o_irq)
        else $error("interrupt without live condition");
    a_brown_holds: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        brown && o_supply_monitor_en && !above_rec |=> brown)
        else $error("brown-out cleared before recovery");
    a_brown_off: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !o_supply_monitor_en |=> !brown)
        else $error("brown-out set while monitor off");
    a_ring_idle: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !ring_en |=> !ring_ins && !ring_unp)
        else $error("ring filter active while powered down");
    a_tip_code: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !ctrl[C_TIP_CTL] |=> !tip_ins && !tip_unp)
        else $error("tip filter active with disabling code");
    a_strap_fixed: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        captured |=> $stable(o_control_bus_select))
        else $error("bus select changed after capture");
endmodule

// ===== testbench/jsd_jack_model.sv
// jack receptacle sense contacts and supply comparators
module jsd_jack_model (
    input  wire logic       i_plug,
    input  wire logic       i_metal,
    input  wire logic       i_bounce,
    input  wire logic [1:0] i_supply,
    output logic            o_tip_sense,
    output logic            o_ring_sense,
    output logic            o_below_trip,
    output logic            o_above_recovery
);
    timeunit 1ns;
    timeprecision 1ps;
    // pulled up when open, shorted low by the plug
    assign o_tip_sense      = ~i_plug ^ i_bounce;
    assign o_ring_sense     = ~(i_plug & i_metal);
    // supply code: 0 below trip, 1 between, 2 above recovery
    assign o_below_trip     = (i_supply == 2'd0);
    assign o_above_recovery = (i_supply == 2'd2);
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the jack sense filter block
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import jsd_pkg::*;
    logic        clk, rstn, cyc, stb, we, plug, metal, bounce, strap;
    logic        ack, tip_s, ring_s, below, above, bus_sel, fe_en, mon_en, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [1:0]  supply;
    int          fail_count, n_tests;

    jsd_top #(.UNIT(4)) dut_u (
        .i_core_clk(clk), .i_resetn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_tip_sense(tip_s), .i_ring_sense(ring_s),
        .i_supply_below_trip(below), .i_supply_above_recovery(above),
        .i_control_bus_select(strap), .o_control_bus_select(bus_sel),
        .o_tip_frontend_en(fe_en), .o_supply_monitor_en(mon_en), .o_irq(irq)
    );
    jsd_jack_model jack_u (
        .i_plug(plug), .i_metal(metal), .i_bounce(bounce), .i_supply(supply),
        .o_tip_sense(tip_s), .o_ring_sense(ring_s),
        .o_below_trip(below), .o_above_recovery(above)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            $display("Error %0t: no bus answer", $time);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_status(input int wait_n);
        repeat (wait_n) @(posedge clk);
        wb(1'b0, ADDR_STATUS, 32'h0);
    endtask

    task automatic t_reset;
        @(posedge clk);
        strap <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(bus_sel, 1'b1)
        repeat (25000) @(posedge clk);
        wb(1'b0, ADDR_CTRL, 32'h0);
        `CHK(q, 32'h0000_0001)
        wb(1'b0, ADDR_TIME, 32'h0);
        `CHK(q, 32'h0000_1111)
        wb(1'b0, ADDR_MASK, 32'h0);
        `CHK(q, 32'h0000_0007)
        wb(1'b0, 8'h10, 32'h0);
        `CHK(q, 32'h0000_0000)
        wb(1'b1, ADDR_STATUS, 32'h0);
        rd_status(0);
        `CHK(q[7:0], 8'h80)
        $display("done reset");
    endtask

    task automatic t_setup;
        wb(1'b1, ADDR_CTRL, 32'h0000_0300);
        `CHK(fe_en, 1'b0)
        wb(1'b1, ADDR_CTRL, 32'h0000_0302);
        repeat (2) @(posedge clk);
        `CHK({fe_en, mon_en}, 2'b11)
        wb(1'b0, ADDR_CTRL, 32'h0);
        `CHK(q, 32'h0000_0300)
        wb(1'b1, ADDR_CTRL, 32'h0000_036C);
        wb(1'b1, ADDR_TIME, 32'h0000_5673);
        wb(1'b1, ADDR_MASK, 32'h0000_0004);
        $display("done setup");
    endtask

    task automatic t_insert;
        plug <= 1'b1;
        repeat (24) @(posedge clk);
        bounce <= 1'b1;
        repeat (4) @(posedge clk);
        bounce <= 1'b0;
        rd_status(12);
        `CHK(q[1:0], 2'b10)
        rd_status(30);
        `CHK(q[5:0], 6'h13)
        `CHK(irq, 1'b1)
        $display("done insert");
    endtask

    task automatic t_ring_gate;
        metal <= 1'b1;
        rd_status(8);
        `CHK(q[3:2], 2'b10)
        rd_status(30);
        `CHK(q[5:0], 6'h3F)
        wb(1'b1, ADDR_CTRL, 32'h0000_03EC);
        rd_status(3);
        `CHK(q[5:4], 2'b10)
        wb(1'b1, ADDR_CTRL, 32'h0000_03CC);
        rd_status(40);
        `CHK(q[5:4], 2'b00)
        wb(1'b1, ADDR_CTRL, 32'h0000_034C);
        rd_status(3);
        `CHK(q[5:4], 2'b10)
        $display("done gating");
    endtask

    task automatic t_enable;
        wb(1'b1, ADDR_CTRL, 32'h0000_0370);
        rd_status(3);
        `CHK(q[3:0], 4'h0)
        wb(1'b1, ADDR_CTRL, 32'h0000_037C);
        rd_status(40);
        `CHK(q[3:0], 4'hF)
        $display("done enable");
    endtask

    task automatic t_remove;
        plug <= 1'b0;
        metal <= 1'b0;
        rd_status(8);
        `CHK(q[3:0], 4'hA)
        `CHK(irq, 1'b0)
        rd_status(15);
        `CHK(q[3:0], 4'h8)
        rd_status(20);
        `CHK(q[3:0], 4'h0)
        $display("done remove");
    endtask

    task automatic t_brown;
        wb(1'b1, ADDR_MASK, 32'h0000_0003);
        supply <= 2'd0;
        rd_status(6);
        `CHK(q[6], 1'b1)
        `CHK(irq, 1'b1)
        supply <= 2'd1;
        rd_status(6);
        `CHK(q[6], 1'b1)
        wb(1'b1, ADDR_MASK, 32'h0000_0007);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        supply <= 2'd2;
        rd_status(6);
        `CHK(q[6], 1'b0)
        wb(1'b1, ADDR_CTRL, 32'h0000_027E);
        supply <= 2'd0;
        rd_status(6);
        `CHK({mon_en, q[6]}, 2'b00)
        $display("done brownout");
    endtask

    initial begin
        fail_count = 0;
        n_tests = 0;
        {rstn, cyc, stb, we, plug, metal, bounce} = 7'h00;
        strap = 1'b1;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        supply = 2'd2;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_setup;
        t_insert;
        t_ring_gate;
        t_enable;
        t_remove;
        t_brown;
        end_of_test;
    end

    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        $display("Error %0t: watchdog expired", $time);
        end_of_test;
    end
endmodule
